//--- src/sbdc_top.sv
// Bus drive control and protocol delay timers for a parallel SCSI port
// How it works
// R01: DT data phases: driver holds P1 false, receiver ignores P1.
// R02: Information unit mode: target holds P_CRCA false, initiator ignores it.
// R03: BSY, SEL and RST are wired-OR lines.
// R04: Wired-OR lines are never driven false, only released.
// R05: Data bit is one when asserted, zero when negated.
// R06: In arbitration P_CRCA and P1 are released or true, never false.
// R07: Drivers that are not active sources sit in high impedance.
// R08: RST may be asserted at any time in any role.
// R09: Bus free and unsourced signals are released to terminator bias.
// R10: Every normally arbitrating device asserts BSY.
// R11: Arbitrating device drives only its own ID bit.
// R12: Only the arbitration winner drives SEL.
// R13: In QAS arbitration BSY comes from the starting target.
// R14: Target-assigned lines are driven only by the active target.
// R15: Initiator-assigned lines are driven only by the active initiator.
// R16: Wait at least 2,4 us after BSY before sampling the data bus.
// R17: Assert BSY and ID 800 ns to 1,6 us after bus free.
// R18: Use 400 ns settle delay; release all within 800 ns clear delay.
// R19: Initiator releases data within 400 ns of I/O going true.
// R20: Reset recognised after 200 ns of RST; own RST held 25 us.
// R21: QAS waits 1000 ns before sampling; QAS signal changes within 200 ns.
// R22: Timing follows the fastest rate of the negotiated range.
// R23: Target waits 200 us after disconnect before arbitrating again.
// R24: Bus free only after BSY and SEL false for a settle delay.
// R25: DT qualifies data on both REQ/ACK edges, ST on assertion only.
// R26: Delays count device clocks, minimums rounded up, maximums down.
// R27: Output enables decode from phase and role per source table.
`include "sbdc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sbdc_top #(
   parameter int unsigned DISC_CYC = `SBDC_DISC_DELAY_CYC
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire sbdc_pkg::sbdc_phase_e phase,
   input wire logic is_target,
   input wire logic [3:0] own_id,
   input wire logic iu_mode,
   input wire sbdc_pkg::sbdc_rate_t rate_range,
   input wire logic arb_req,
   input wire logic qas_req,
   input wire logic qas_pt,
   input wire logic disc_done,
   input wire logic rst_req,
   input wire sbdc_pkg::sbdc_bus_s usr_val,
   input wire sbdc_pkg::sbdc_bus_s usr_en,
   input wire sbdc_pkg::sbdc_bus_s bus_i,
   output sbdc_pkg::sbdc_bus_s bus_o,
   output sbdc_pkg::sbdc_bus_s bus_oe,
   output logic [15:0] rx_db,
   output logic rx_p1,
   output logic rx_crca,
   output logic data_stb,
   output logic bus_free,
   output logic arb_won,
   output logic arb_lost,
   output logic bus_reset,
   output logic [4:0] xfer_period
);
   localparam logic [7:0] SETTLE = 8'(`SBDC_SETTLE_CYC);
   localparam logic [7:0] BF_MIN = 8'(`SBDC_SETTLE_CYC + `SBDC_BUS_FREE_CYC);
   // Two cycles of margin cover the decision flop and the output flop
   localparam logic [7:0] BF_MAX = 8'(`SBDC_SETTLE_CYC + `SBDC_BUS_SET_CYC - 2);
   localparam logic [4:0] RST_DLY = 5'(`SBDC_RST_DELAY_CYC);

   sbdc_pkg::sbdc_state_e st_q;
   sbdc_pkg::sbdc_phase_e eff_ph;
   sbdc_pkg::sbdc_bus_s dec_oe, dec_val;
   logic [7:0] free_cnt_q, free_cnt_d;
   logic [4:0] rst_cnt_q, rst_cnt_d;
   logic qas_q, stb_prev_q, stb_sig, rst_ext, rst_drive, release_all;
   logic arb_start, lose, arb_busy, arb_done, rst_busy, disc_busy;
   logic bus_idle, qas_ok, higher;

   function automatic logic [4:0] prio_rank(input logic [3:0] id);
      return id[3] ? 5'(23 - int'(id)) : 5'(7 - int'(id));
   endfunction : prio_rank

   function automatic logic beaten(input logic [15:0] db,
                                   input logic [3:0] id);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (db[i] && prio_rank(4'(i)) < prio_rank(id)) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : beaten

   function automatic logic [4:0] period_cyc(input sbdc_pkg::sbdc_rate_t r,
                                             input logic dt);
      int ns;
      ns = `SBDC_ST_F40_NS;
      if (dt) begin
         case (r)
            2'h0: ns = `SBDC_DT_F10_NS;
            2'h1: ns = `SBDC_DT_F20_NS;
            2'h2: ns = `SBDC_DT_F40_NS;
            default: ns = `SBDC_DT_F80_NS;
         endcase
      end else begin
         case (r)
            2'h0: ns = `SBDC_ST_F5_NS;
            2'h1: ns = `SBDC_ST_F10_NS;
            2'h2: ns = `SBDC_ST_F20_NS;
            default: ns = `SBDC_ST_F40_NS;
         endcase
      end
      return 5'(`SBDC_CEIL(ns));
   endfunction : period_cyc

   // Bus free and bus reset filters
   assign bus_idle = !bus_i.bsy && !bus_i.sel;
   assign free_cnt_d = !bus_idle ? 8'h00 :
      (free_cnt_q == 8'hFF ? 8'hFF : free_cnt_q + 8'h01);
   assign rst_cnt_d = !bus_i.rst ? 5'h00 :
      (rst_cnt_q == 5'h1F ? 5'h1F : rst_cnt_q + 5'h01);
   // Own RST is not a bus reset for this device, only for the others
   assign rst_ext = bus_i.rst && !rst_drive;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         free_cnt_q <= 8'h00;
         bus_free <= 1'b0;
      end else begin
         free_cnt_q <= free_cnt_d;
         bus_free <= free_cnt_d >= SETTLE; // R24 R18
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rst_cnt_q <= 5'h00;
         bus_reset <= 1'b0;
      end else begin
         rst_cnt_q <= rst_cnt_d;
         bus_reset <= (rst_cnt_d == RST_DLY) && !rst_drive; // R20
      end
   end

   // Own RST: held for the full hold time even if the request is short
   sbdc_timer u_rst_tmr (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(rst_req && !rst_busy),
      .load(15'(`SBDC_RST_HOLD_CYC)), // R20 R26
      .busy(rst_busy),
      .done()
   );
   assign rst_drive = rst_req || rst_busy; // R08

   sbdc_timer u_disc_tmr (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(disc_done && is_target),
      .load(15'(DISC_CYC)), // R23
      .busy(disc_busy),
      .done()
   );

   // Arbitration control
   assign qas_ok = qas_req && !bus_i.cd && !bus_i.io && !bus_i.msg;
   assign arb_start = (st_q == sbdc_pkg::SBDC_ST_IDLE) && !disc_busy && // R23
      !rst_ext && !rst_drive &&
      ((arb_req && free_cnt_q >= BF_MIN && free_cnt_q <= BF_MAX) || qas_ok);
   assign higher = beaten(bus_i.db, own_id);
   // Another device's SEL during arbitration ends our attempt
   assign lose = (st_q == sbdc_pkg::SBDC_ST_ARB) &&
      ((bus_i.sel && !bus_oe.sel) || (arb_done && higher));

   // Load adds one cycle because BSY leaves the output flop a cycle later
   sbdc_timer u_arb_tmr (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .start(arb_start),
      .load(qas_ok ? 15'(`SBDC_QAS_ARB_CYC + 1) // R21
                   : 15'(`SBDC_ARB_DELAY_CYC + 1)), // R16 R26
      .busy(arb_busy),
      .done(arb_done)
   );

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q <= sbdc_pkg::SBDC_ST_IDLE;
         qas_q <= 1'b0;
      end else if (rst_ext) begin
         st_q <= sbdc_pkg::SBDC_ST_IDLE; // R18
      end else begin
         case (st_q)
            sbdc_pkg::SBDC_ST_IDLE: begin
               if (arb_start) begin
                  st_q <= sbdc_pkg::SBDC_ST_ARB; // R17
                  qas_q <= qas_ok;
               end
            end
            sbdc_pkg::SBDC_ST_ARB: begin
               if (lose) begin
                  st_q <= sbdc_pkg::SBDC_ST_IDLE;
               end else if (arb_done) begin
                  st_q <= sbdc_pkg::SBDC_ST_WON; // R16
               end
            end
            sbdc_pkg::SBDC_ST_WON: begin
               if (!arb_req && !qas_req) begin
                  st_q <= sbdc_pkg::SBDC_ST_IDLE;
               end
            end
            default: st_q <= sbdc_pkg::SBDC_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         arb_won <= 1'b0;
         arb_lost <= 1'b0;
      end else begin
         arb_won <= (st_q == sbdc_pkg::SBDC_ST_ARB && arb_done && !lose) ||
            (st_q == sbdc_pkg::SBDC_ST_WON && (arb_req || qas_req));
         arb_lost <= lose;
      end
   end

   // Drive decode; a device that is not arbitrating, or has lost, keeps off
   // the bus in arbitration, except the QAS starter, which keeps its BSY and its own ID bit
   assign eff_ph = (st_q != sbdc_pkg::SBDC_ST_IDLE) ?
      (qas_q ? sbdc_pkg::SBDC_PH_QAS_ARB : sbdc_pkg::SBDC_PH_ARB) :
      (phase == sbdc_pkg::SBDC_PH_ARB ||
       (phase == sbdc_pkg::SBDC_PH_QAS_ARB && !qas_pt)) ?
      sbdc_pkg::SBDC_PH_FREE : phase; // R11 R12
   // Releasing within one cycle keeps well inside the clear delay
   assign release_all = rst_ext ||
      (st_q == sbdc_pkg::SBDC_ST_IDLE && phase == sbdc_pkg::SBDC_PH_FREE);

   sbdc_drive_dec u_dec (
      .ph(eff_ph),
      .is_target(is_target),
      .won(st_q == sbdc_pkg::SBDC_ST_WON),
      .qas_pt(qas_pt),
      .own_id(own_id),
      .iu_mode(iu_mode),
      .rst_drive(rst_drive),
      .release_all(release_all),
      .usr_val(usr_val),
      .usr_en(usr_en),
      .oe(dec_oe),
      .val(dec_val)
   );

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bus_oe <= '0;
         bus_o <= '0;
      end else begin
         bus_oe <= dec_oe; // R07 R27
         bus_o <= dec_val; // R04 R06
      end
   end

   // Receive side: qualify data on REQ/ACK edges seen from our role
   assign stb_sig = is_target ? bus_i.ack : bus_i.req;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stb_prev_q <= 1'b0;
         data_stb <= 1'b0;
         rx_db <= 16'h0000;
         rx_p1 <= 1'b0;
         rx_crca <= 1'b0;
         xfer_period <= 5'h00;
      end else begin
         stb_prev_q <= stb_sig;
         xfer_period <= period_cyc(rate_range, sbdc_pkg::sbdc_is_dt(phase)); // R22
         data_stb <= (stb_sig && !stb_prev_q) ||
            (sbdc_pkg::sbdc_is_dt(phase) && !stb_sig && stb_prev_q); // R25
         rx_db <= bus_i.db; // R05
         rx_p1 <= bus_i.p1 && !sbdc_pkg::sbdc_is_dt(phase); // R01
         rx_crca <= bus_i.p_crca &&
            !(sbdc_pkg::sbdc_is_dt(phase) && iu_mode && !is_target); // R02
      end
   end

   // Helper counters for the checks below
   logic [11:0] rst_on_q;
   logic [7:0] arb_age_q;
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rst_on_q <= 12'h000;
         arb_age_q <= 8'h00;
      end else begin
         rst_on_q <= bus_oe.rst ? (rst_on_q == 12'hFFF ? 12'hFFF
                                   : rst_on_q + 12'h001) : 12'h000;
         arb_age_q <= (st_q != sbdc_pkg::SBDC_ST_ARB) ? 8'h00 :
            (arb_age_q == 8'hFF ? 8'hFF : arb_age_q + 8'h01);
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_wor_true_only: assert property ( // R04
      (bus_oe.bsy |-> bus_o.bsy) and (bus_oe.sel |-> bus_o.sel) and
      (bus_oe.rst |-> bus_o.rst))
      else $error("wired-OR line driven false");
   a_arb_parity_high: assert property ( // R06
      $past(st_q == sbdc_pkg::SBDC_ST_ARB) |->
      !(bus_oe.p_crca && !bus_o.p_crca) && !(bus_oe.p1 && !bus_o.p1))
      else $error("parity line driven false in arbitration");
   a_dt_p1_neg: assert property ( // R01
      $past(sbdc_pkg::sbdc_is_dt(eff_ph)) && bus_oe.p1 |-> !bus_o.p1)
      else $error("P1 driven true in DT phase");
   a_iu_crca_neg: assert property ( // R02
      $past(sbdc_pkg::sbdc_is_dt(eff_ph) && iu_mode) && bus_oe.p_crca
      |-> !bus_o.p_crca)
      else $error("P_CRCA true in information unit mode");
   a_rst_hold_min: assert property ( // R20
      $fell(bus_oe.rst) |-> $past(rst_on_q) >= 12'(`SBDC_RST_HOLD_CYC))
      else $error("own RST released too early");
   a_arb_id_only: assert property ( // R11
      $past(st_q == sbdc_pkg::SBDC_ST_ARB && !release_all) |->
      bus_oe.db == (16'h0001 << $past(own_id)))
      else $error("arbitration drives more than own ID");
   a_arb_wait_min: assert property ( // R16
      $rose(arb_won) && !$past(qas_q) |->
      $past(arb_age_q) >= 8'(`SBDC_ARB_DELAY_CYC))
      else $error("arbitration decided too early");
   a_free_settle: assert property ( // R24
      $rose(bus_free) |-> $past(!bus_i.bsy && !bus_i.sel, 1) &&
      $past(free_cnt_q) >= 8'(`SBDC_SETTLE_CYC - 1))
      else $error("bus free without settle delay");
   a_rst_release: assert property ( // R18
      rst_ext |=> bus_oe.bsy == 1'b0 && bus_oe.db == 16'h0000)
      else $error("signals held after bus reset");
   a_bus_set_max: assert property ( // R17
      arb_start && !qas_ok |-> ##[1:2] bus_oe.bsy)
      else $error("BSY not asserted in time");
   a_st_one_edge: assert property ( // R25
      data_stb && !sbdc_pkg::sbdc_is_dt($past(phase)) |->
      $past(stb_sig) && !$past(stb_prev_q))
      else $error("ST data qualified on negation edge");
endmodule : sbdc_top
`default_nettype wire

//--- include/sbdc_consts.svh
// Timing constants for the bus drive control and timers block
`ifndef SBDC_CONSTS_SVH
`define SBDC_CONSTS_SVH
`define SBDC_CLK_PERIOD_NS 10
`define SBDC_CEIL(ns) (((ns) + `SBDC_CLK_PERIOD_NS - 1) / `SBDC_CLK_PERIOD_NS)
`define SBDC_FLOOR(ns) ((ns) / `SBDC_CLK_PERIOD_NS)
`define SBDC_ARB_DELAY_NS 2400
`define SBDC_BUS_CLEAR_NS 800
`define SBDC_BUS_FREE_NS 800
`define SBDC_BUS_SET_NS 1600
`define SBDC_BUS_SETTLE_NS 400
`define SBDC_QAS_ARB_NS 1000
`define SBDC_QAS_ASSERT_NS 200
`define SBDC_RST_DELAY_NS 200
`define SBDC_RST_HOLD_US 25
`define SBDC_DISC_DELAY_US 200
`define SBDC_ARB_DELAY_CYC `SBDC_CEIL(`SBDC_ARB_DELAY_NS)
`define SBDC_BUS_FREE_CYC `SBDC_CEIL(`SBDC_BUS_FREE_NS)
`define SBDC_BUS_SET_CYC `SBDC_FLOOR(`SBDC_BUS_SET_NS)
`define SBDC_SETTLE_CYC `SBDC_CEIL(`SBDC_BUS_SETTLE_NS)
`define SBDC_QAS_ARB_CYC `SBDC_CEIL(`SBDC_QAS_ARB_NS)
`define SBDC_RST_DELAY_CYC `SBDC_CEIL(`SBDC_RST_DELAY_NS)
`define SBDC_RST_HOLD_CYC `SBDC_CEIL(`SBDC_RST_HOLD_US * 1000)
`define SBDC_DISC_DELAY_CYC `SBDC_CEIL(`SBDC_DISC_DELAY_US * 1000)
`define SBDC_ST_F5_NS 200
`define SBDC_ST_F10_NS 100
`define SBDC_ST_F20_NS 50
`define SBDC_ST_F40_NS 25
`define SBDC_DT_F10_NS 200
`define SBDC_DT_F20_NS 100
`define SBDC_DT_F40_NS 50
`define SBDC_DT_F80_NS 25
`endif

//--- include/sbdc_pkg.sv
// Types shared by the bus drive control and timers block
package sbdc_pkg;
   typedef enum logic [3:0] {
      SBDC_PH_FREE = 4'b0000,
      SBDC_PH_ARB = 4'b0001,
      SBDC_PH_QAS_ARB = 4'b0010,
      SBDC_PH_SEL = 4'b0011,
      SBDC_PH_RESEL = 4'b0100,
      SBDC_PH_CMD = 4'b0101,
      SBDC_PH_ST_IN = 4'b0110,
      SBDC_PH_ST_OUT = 4'b0111,
      SBDC_PH_DT_IN = 4'b1000,
      SBDC_PH_DT_OUT = 4'b1001,
      SBDC_PH_STATUS = 4'b1010,
      SBDC_PH_MSG_IN = 4'b1011,
      SBDC_PH_MSG_OUT = 4'b1100
   } sbdc_phase_e;

   typedef enum logic [1:0] {
      SBDC_SRC_NONE = 2'b00,
      SBDC_SRC_TARG = 2'b01,
      SBDC_SRC_INIT = 2'b10
   } sbdc_src_e;

   // Rate range: 0..3 is slowest to fastest range of the mode
   typedef logic [1:0] sbdc_rate_t;

   typedef enum logic [1:0] {
      SBDC_ST_IDLE = 2'b00,
      SBDC_ST_ARB = 2'b01,
      SBDC_ST_WON = 2'b10
   } sbdc_state_e;

   typedef struct packed {
      logic bsy;
      logic sel;
      logic rst;
      logic cd;
      logic io;
      logic msg;
      logic req;
      logic ack;
      logic atn;
      logic [15:0] db;
      logic p_crca;
      logic p1;
   } sbdc_bus_s;

   function automatic logic sbdc_is_dt(input sbdc_phase_e ph);
      return (ph == SBDC_PH_DT_IN) || (ph == SBDC_PH_DT_OUT);
   endfunction : sbdc_is_dt
endpackage : sbdc_pkg

//--- src/sbdc_timer.sv
// Load-and-count-down delay timer
`timescale 1ns/1ps
`default_nettype none
module sbdc_timer (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [14:0] load,
   output logic busy,
   output logic done
);
   logic [14:0] cnt_q;

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= 15'h0000;
      end else if (start) begin
         cnt_q <= load;
      end else if (cnt_q != 15'h0000) begin
         cnt_q <= cnt_q - 15'h0001;
      end
   end

   assign busy = (cnt_q != 15'h0000);
   assign done = (cnt_q == 15'h0001);
endmodule : sbdc_timer
`default_nettype wire

//--- src/sbdc_drive_dec.sv
// Output enable and drive value decode per bus phase and role
`timescale 1ns/1ps
`default_nettype none
module sbdc_drive_dec (
   input wire sbdc_pkg::sbdc_phase_e ph,
   input wire logic is_target,
   input wire logic won,
   input wire logic qas_pt,
   input wire logic [3:0] own_id,
   input wire logic iu_mode,
   input wire logic rst_drive,
   input wire logic release_all,
   input wire sbdc_pkg::sbdc_bus_s usr_val,
   input wire sbdc_pkg::sbdc_bus_s usr_en,
   output sbdc_pkg::sbdc_bus_s oe,
   output sbdc_pkg::sbdc_bus_s val
);
   sbdc_pkg::sbdc_src_e s_ctl, s_ini, s_lo, s_crca, s_hi;
   logic dt;

   function automatic logic owns(input sbdc_pkg::sbdc_src_e s,
                                 input logic tgt);
      return (s == sbdc_pkg::SBDC_SRC_TARG && tgt) ||
             (s == sbdc_pkg::SBDC_SRC_INIT && !tgt);
   endfunction : owns

   always_comb begin
      s_ctl = sbdc_pkg::SBDC_SRC_TARG;
      s_ini = sbdc_pkg::SBDC_SRC_INIT;
      s_lo = sbdc_pkg::SBDC_SRC_NONE;
      s_crca = sbdc_pkg::SBDC_SRC_NONE;
      s_hi = sbdc_pkg::SBDC_SRC_NONE;
      case (ph)
         sbdc_pkg::SBDC_PH_SEL: begin
            s_ctl = sbdc_pkg::SBDC_SRC_NONE;
            s_lo = sbdc_pkg::SBDC_SRC_INIT;
            s_crca = sbdc_pkg::SBDC_SRC_INIT;
            s_hi = sbdc_pkg::SBDC_SRC_INIT;
         end
         sbdc_pkg::SBDC_PH_RESEL, sbdc_pkg::SBDC_PH_ST_IN,
         sbdc_pkg::SBDC_PH_DT_IN: begin
            s_lo = sbdc_pkg::SBDC_SRC_TARG;
            s_crca = sbdc_pkg::SBDC_SRC_TARG;
            s_hi = sbdc_pkg::SBDC_SRC_TARG;
         end
         sbdc_pkg::SBDC_PH_CMD, sbdc_pkg::SBDC_PH_MSG_OUT: begin
            s_lo = sbdc_pkg::SBDC_SRC_INIT;
            s_crca = sbdc_pkg::SBDC_SRC_INIT;
         end
         sbdc_pkg::SBDC_PH_ST_OUT: begin
            s_lo = sbdc_pkg::SBDC_SRC_INIT;
            s_crca = sbdc_pkg::SBDC_SRC_INIT;
            s_hi = sbdc_pkg::SBDC_SRC_INIT;
         end
         sbdc_pkg::SBDC_PH_DT_OUT: begin
            s_lo = sbdc_pkg::SBDC_SRC_INIT;
            s_crca = sbdc_pkg::SBDC_SRC_TARG;
            s_hi = sbdc_pkg::SBDC_SRC_INIT;
         end
         sbdc_pkg::SBDC_PH_STATUS, sbdc_pkg::SBDC_PH_MSG_IN: begin
            s_lo = sbdc_pkg::SBDC_SRC_TARG;
            s_crca = sbdc_pkg::SBDC_SRC_TARG;
         end
         default: begin
            s_ctl = sbdc_pkg::SBDC_SRC_NONE;
            s_ini = sbdc_pkg::SBDC_SRC_NONE;
         end
      endcase
   end

   assign dt = sbdc_pkg::sbdc_is_dt(ph);

   always_comb begin
      oe = '0;
      val = '0;
      // Wired-OR lines only ever drive true; negation is a release
      val.bsy = 1'b1; // R03 R04
      val.sel = 1'b1; // R03 R04
      val.rst = 1'b1; // R03 R04
      if (ph == sbdc_pkg::SBDC_PH_ARB || ph == sbdc_pkg::SBDC_PH_QAS_ARB) begin
         oe.bsy = (ph == sbdc_pkg::SBDC_PH_ARB) || qas_pt; // R10 R13
         oe.sel = won; // R12
         oe.db = 16'h0001 << own_id; // R11
         val.db = 16'h0001 << own_id; // R05
         // Parity lines left released so they are never driven false
         oe.p_crca = 1'b0; // R06
         oe.p1 = 1'b0; // R06
      end else if (ph != sbdc_pkg::SBDC_PH_FREE) begin // R09
         if (ph == sbdc_pkg::SBDC_PH_SEL || ph == sbdc_pkg::SBDC_PH_RESEL) begin
            oe.bsy = usr_en.bsy;
            oe.sel = usr_en.sel &&
               (ph == sbdc_pkg::SBDC_PH_SEL ? !is_target : is_target);
         end else begin
            oe.bsy = usr_en.bsy && is_target; // R14
         end
         oe.cd = usr_en.cd && owns(s_ctl, is_target); // R14
         oe.io = usr_en.io && owns(s_ctl, is_target); // R14
         oe.msg = usr_en.msg && owns(s_ctl, is_target); // R14
         oe.req = usr_en.req && owns(s_ctl, is_target); // R14
         oe.ack = usr_en.ack && owns(s_ini, is_target); // R27
         oe.atn = usr_en.atn && owns(s_ini, is_target); // R27
         oe.db[7:0] = owns(s_lo, is_target) ? usr_en.db[7:0] : 8'h00; // R27
         oe.db[15:8] = owns(s_hi, is_target) ? usr_en.db[15:8] : 8'h00;
         oe.p_crca = usr_en.p_crca && owns(s_crca, is_target); // R14
         oe.p1 = usr_en.p1 && owns(s_hi, is_target); // R27
         val.cd = usr_val.cd;
         val.io = usr_val.io;
         val.msg = usr_val.msg;
         val.req = usr_val.req;
         val.ack = usr_val.ack;
         val.atn = usr_val.atn;
         val.db = usr_val.db; // R05
         val.p1 = usr_val.p1 && !dt; // R01
         val.p_crca = usr_val.p_crca && !(dt && iu_mode); // R02
      end
      if (release_all) begin
         oe = '0; // R18 R07
      end
      oe.rst = rst_drive; // R08
   end
endmodule : sbdc_drive_dec
`default_nettype wire

//--- sim/sbdc_partner.sv
// Other devices on the cable, wired-OR with our drivers
`timescale 1ns/1ps
`default_nettype none
module sbdc_partner (
   input wire sbdc_pkg::sbdc_bus_s p_en,
   input wire sbdc_pkg::sbdc_bus_s p_val,
   input wire sbdc_pkg::sbdc_bus_s d_oe,
   input wire sbdc_pkg::sbdc_bus_s d_val,
   output sbdc_pkg::sbdc_bus_s bus
);
   // Released lines read false through the terminator bias; a far initiator
   // lets go of the data lines once our I/O turns true
   assign bus = (p_en & p_val & ~{9'h000, {16{d_oe.io & d_val.io}}, 2'h0}) |
      (d_oe & d_val);
endmodule : sbdc_partner
`default_nettype wire

//--- sim/scsi_bus_drive_control_timers_tb.sv
// Self-checking bench for the bus drive control and timers block
`timescale 1ns/1ps
`default_nettype none
module scsi_bus_drive_control_timers_tb;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   sbdc_pkg::sbdc_phase_e phase = sbdc_pkg::SBDC_PH_FREE;
   logic is_target = 1'b0;
   logic iu_mode = 1'b0;
   logic arb_req = 1'b0;
   logic rst_req = 1'b0;
   logic qas_req = 1'b0, qas_pt = 1'b0, disc_done = 1'b0;
   logic [3:0] own_id = 4'h7;
   sbdc_pkg::sbdc_rate_t rate_range = 2'h0;
   sbdc_pkg::sbdc_bus_s usr_val = '1;
   sbdc_pkg::sbdc_bus_s usr_en = '1;
   sbdc_pkg::sbdc_bus_s p_en = '0;
   sbdc_pkg::sbdc_bus_s p_val = '1;
   sbdc_pkg::sbdc_bus_s bus_i, bus_o, bus_oe;
   logic [15:0] rx_db, d;
   logic rx_p1, rx_crca, data_stb, bus_free, arb_won, arb_lost, bus_reset;
   logic [4:0] xfer_period;
   int failures = 0;
   int samples_checked = 0;
   int n, sel_seen, rst_seen = 0, stb_seen = 0;
   sbdc_partner i_far (.p_en(p_en), .p_val(p_val), .d_oe(bus_oe),
      .d_val(bus_o), .bus(bus_i));
   // Shortened disconnect wait keeps the run brief
   sbdc_top #(.DISC_CYC(50)) i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .phase(phase), .is_target(is_target), .own_id(own_id),
      .iu_mode(iu_mode), .rate_range(rate_range), .arb_req(arb_req),
      .qas_req(qas_req), .qas_pt(qas_pt), .disc_done(disc_done),
      .rst_req(rst_req),
      .usr_val(usr_val), .usr_en(usr_en), .bus_i(bus_i), .bus_o(bus_o),
      .bus_oe(bus_oe), .rx_db(rx_db), .rx_p1(rx_p1), .rx_crca(rx_crca),
      .data_stb(data_stb), .bus_free(bus_free), .arb_won(arb_won),
      .arb_lost(arb_lost), .bus_reset(bus_reset),
      .xfer_period(xfer_period));
   initial forever #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      rst_seen <= rst_seen + int'(bus_reset === 1'b1);
      stb_seen <= stb_seen + int'(data_stb === 1'b1);
   end
   task automatic tick(input int k = 1);
      repeat (k) @(negedge ref_clk);
   endtask : tick
   task automatic chk(input string w, input logic [31:0] e,
                      input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s exp %0h got %0h", w, e, g);
      end
   endtask : chk
   task automatic report_and_stop;
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic bound(input int lim);
      if (n >= lim) begin
         failures++;
         report_and_stop();
      end
   endtask : bound
   // Rival, when set, raises BSY and the top-priority ID bit one cycle late;
   // q asks for QAS arbitration as the target that started it
   task automatic arb(input logic [3:0] id, input logic rival,
                      input logic q = 1'b0);
      tick(140);
      own_id = id;
      phase = sbdc_pkg::SBDC_PH_ARB;
      arb_req = !q;
      qas_req = q;
      qas_pt = q;
      tick();
      p_en.bsy = rival;
      p_en.db = rival ? 16'h0080 : 16'h0000;
      tick();
      chk("bsy", 32'h1, bus_oe.bsy & bus_o.bsy);
      chk("id", 16'h0001 << id, bus_oe.db);
      chk("p1", 32'h0, bus_oe.p1 & ~bus_o.p1);
      n = 1;
      sel_seen = 0;
      while (arb_won !== 1'b1 && arb_lost !== 1'b1 && n < 400) begin
         sel_seen |= bus_oe.sel;
         tick();
         n++;
      end
      bound(400);
      chk("arb delay", 32'h1, $unsigned(n - (q ? 101 : 241)) <= 2);
      chk("sel early", 32'h0, sel_seen);
   endtask : arb
   initial begin
      n = $urandom(32'h091C678D);
      tick(20);
      sys_rst = 1'b0;
      chk("rst oe", 32'h0, bus_oe);
      usr_val = sbdc_pkg::sbdc_bus_s'($urandom);
      tick(39);
      chk("free 39", 32'h0, bus_free);
      tick();
      chk("free 40", 32'h1, bus_free);
      chk("free oe", 32'h0, bus_oe);
      $display("test bus_free done");
      for (int q = 0; q < 2; q++) begin
         arb(4'h7, 1'b0, q[0]);
         chk("won", 32'h1, arb_won);
         tick();
         chk("sel win", 32'h1, bus_oe.sel & bus_o.sel);
         arb_req = 1'b0;
         qas_req = 1'b0;
         phase = sbdc_pkg::SBDC_PH_FREE;
         tick(5);
      end
      arb(4'($urandom_range(6, 0)), 1'b1);
      chk("lost", 32'h1, arb_lost);
      tick();
      chk("sel lose", 32'h0, bus_oe.sel);
      arb_req = 1'b0;
      p_en = '0;
      phase = sbdc_pkg::SBDC_PH_FREE;
      $display("test arbitration done");
      tick(5);
      p_en.rst = 1'b1;
      tick(19);
      p_en.rst = 1'b0;
      tick(5);
      chk("short rst", 32'h0, rst_seen);
      p_en.rst = 1'b1;
      tick(25);
      p_en.rst = 1'b0;
      tick(5);
      chk("bus rst", 32'h1, rst_seen);
      rst_req = 1'b1;
      tick(2);
      rst_req = 1'b0;
      n = 0;
      while (bus_oe.rst === 1'b1 && n < 3000) begin
         tick();
         n++;
      end
      bound(3000);
      chk("rst hold", 32'h1, n >= 2499);
      chk("own rst", 32'h1, rst_seen);
      $display("test reset done");
      iu_mode = 1'b1;
      for (int k = 0; k < 2; k++) begin
         phase = k ? sbdc_pkg::SBDC_PH_ST_IN : sbdc_pkg::SBDC_PH_DT_IN;
         n = stb_seen;
         p_en.req = 1'b1;
         tick(3);
         p_en.req = 1'b0;
         tick(3);
         chk("stb", 32'(2 - k), 32'(stb_seen - n));
      end
      d = 16'($urandom);
      phase = sbdc_pkg::SBDC_PH_DT_IN;
      p_val.db = d;
      p_en.db = 16'hFFFF;
      p_en.p1 = 1'b1;
      p_en.p_crca = 1'b1;
      tick(3);
      chk("rx db", d, rx_db);
      chk("rx p1", 32'h0, rx_p1);
      chk("rx crca", 32'h0, rx_crca);
      chk("init db", 32'h0, bus_oe.db | bus_oe.req);
      p_en = '0;
      phase = sbdc_pkg::SBDC_PH_DT_OUT;
      tick(3);
      chk("out p1", 32'h0, bus_oe.p1 & bus_o.p1);
      chk("out crca", 32'h0, bus_oe.p_crca);
      is_target = 1'b1;
      phase = sbdc_pkg::SBDC_PH_DT_IN;
      tick(3);
      chk("tgt crca", 32'h0, bus_oe.p_crca & bus_o.p_crca);
      chk("tgt ack", 32'h0, bus_oe.ack);
      for (int r = 0; r < 8; r++) begin
         phase = r < 4 ? sbdc_pkg::SBDC_PH_DT_IN : sbdc_pkg::SBDC_PH_ST_IN;
         rate_range = 2'(r);
         tick(3);
         chk("period", 32'((199 >> r[1:0]) / 10 + 1), xfer_period);
      end
      $display("test data phases done");
      phase = sbdc_pkg::SBDC_PH_FREE;
      tick(100);
      disc_done = 1'b1;
      tick();
      disc_done = 1'b0;
      arb_req = 1'b1;
      tick(40);
      chk("disc wait", 32'h0, bus_oe.bsy);
      tick(12);
      chk("disc arb", 32'h1, bus_oe.bsy);
      $display("test disconnect done");
      report_and_stop();
   end
endmodule : scsi_bus_drive_control_timers_tb
`default_nettype wire
